// File: core/ofd_cfg.svh
/*
 * Constants of the overrange and fast-detect block: register offsets,
 * field widths, reset values and serial port framing.
 * Assumes it is included once through its guard, by ofd_pkg.
 */
`ifndef OFD_CFG_SVH
`define OFD_CFG_SVH

`define OFD_ADDR_W 15
`define OFD_SAMPLE_W 14
`define OFD_THR_W 13
`define OFD_DWELL_W 16
`define OFD_VC_N 8
`define OFD_VC_W 3

`define OFD_ADDR_UPPER_P0 15'h0247
`define OFD_ADDR_UPPER_P1 15'h0248
`define OFD_ADDR_LOWER_P0 15'h0249
`define OFD_ADDR_LOWER_P1 15'h024A
`define OFD_ADDR_DWELL_P0 15'h024B
`define OFD_ADDR_DWELL_P1 15'h024C
`define OFD_ADDR_OVR_CLR 15'h0562
`define OFD_ADDR_OVR_STAT 15'h0563

`define OFD_UPPER_RST 13'h1FFF
`define OFD_LOWER_RST 13'h0000
`define OFD_DWELL_RST 16'h0001
`define OFD_CLR_RST 8'h00

`define OFD_SPI_CMD_BITS 5'h10
`define OFD_SPI_ALL_BITS 5'h18
`define OFD_SYNC_SCLK 0
`define OFD_SYNC_CSB 1
`define OFD_SYNC_SDI 2

`endif

// File: core/ofd_pkg.sv
/*
 * Types shared by the overrange and fast-detect block.
 * Assumes ofd_cfg.svh is on the include path.
 */
package ofd_pkg;

`include "ofd_cfg.svh"

typedef struct packed {
    logic wr;
    logic [`OFD_ADDR_W-1:0] addr;
    logic [7:0] wdata;
} ofd_bus_s;

typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_d;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic rd_mode;
    logic load;
    logic [7:0] tx;
    logic sdo;
    logic sdo_oe;
    ofd_bus_s bus;
} ofd_spi_s;

typedef struct packed {
    logic [`OFD_THR_W-1:0] upper;
    logic [`OFD_THR_W-1:0] lower;
    logic [`OFD_DWELL_W-1:0] dwell;
    logic [`OFD_VC_N-1:0] clr;
    logic [`OFD_VC_N-1:0] sticky;
    logic [`OFD_SAMPLE_W-1:0] mag;
    logic [`OFD_SAMPLE_W-1:0] data;
    logic ctrl_bit;
    logic alarm;
    logic [`OFD_DWELL_W:0] dwell_cnt;
} ofd_core_s;

endpackage

// File: core/ofd_spi.sv
/*
 * Serial control port slave: 16 instruction bits (read flag, 15-bit
 * address) then 8 data bits, MSB first, sampled on rising sclk, read
 * data shifted out on falling sclk. One byte per chip-select frame.
 * Assumes sclk is at most one eighth of ref_clk so the synchronised
 * edges are seen; pins arrive asynchronously and are synchronised here.
 */
`timescale 1ns/10ps

module ofd_spi
    import ofd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_sync_b,
    input wire logic spi_sclk,
    input wire logic spi_csb,
    input wire logic spi_sdi,
    input wire logic [7:0] rd_data,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    output ofd_bus_s bus
);

    ofd_spi_s st_r;
    ofd_spi_s st_nxt;

    always_comb begin
        logic sclk;
        logic csb;
        logic rise;
        logic fall;
        sclk = st_r.sync2[`OFD_SYNC_SCLK];
        csb = st_r.sync2[`OFD_SYNC_CSB];
        rise = sclk && !st_r.sclk_d;
        fall = !sclk && st_r.sclk_d;
        st_nxt = st_r;
        st_nxt.sync1 = {spi_sdi, spi_csb, spi_sclk};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sclk_d = sclk;
        st_nxt.bus.wr = 1'b0;
        st_nxt.load = 1'b0;
        if (csb) begin
            st_nxt.bit_cnt = 5'h00;
            st_nxt.rd_mode = 1'b0;
            st_nxt.sdo_oe = 1'b0;
        end else begin
            if (rise && st_r.bit_cnt < `OFD_SPI_ALL_BITS) begin
                st_nxt.shift = {st_r.shift[14:0], st_r.sync2[`OFD_SYNC_SDI]};
                st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
                if (st_r.bit_cnt == `OFD_SPI_CMD_BITS - 5'h01) begin
                    st_nxt.rd_mode = st_r.shift[14];
                    st_nxt.load = st_r.shift[14];
                    st_nxt.bus.addr = {st_r.shift[13:0], st_r.sync2[`OFD_SYNC_SDI]};
                end
                if (st_r.bit_cnt == `OFD_SPI_ALL_BITS - 5'h01 && !st_r.rd_mode) begin
                    st_nxt.bus.wr = 1'b1;
                    st_nxt.bus.wdata = {st_r.shift[6:0], st_r.sync2[`OFD_SYNC_SDI]};
                end
            end
            // Register the read byte one cycle after the address settles
            if (st_r.load) begin
                st_nxt.tx = rd_data;
            end
            if (fall && st_r.rd_mode && st_r.bit_cnt >= `OFD_SPI_CMD_BITS
                    && st_r.bit_cnt < `OFD_SPI_ALL_BITS) begin
                st_nxt.sdo = st_r.tx[7];
                st_nxt.tx = {st_r.tx[6:0], 1'b0};
                st_nxt.sdo_oe = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r <= '0;
            st_r.sync1 <= 3'h2;
            st_r.sync2 <= 3'h2;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign spi_sdo = st_r.sdo;
    assign spi_sdo_oe = st_r.sdo_oe;
    assign bus = st_r.bus;

endmodule

// File: core/ofd_top.sv
/*
 * Overrange and fast-detect block: threshold alarm with dwell hysteresis,
 * overrange control bit beside each sample, per virtual converter sticky
 * overrange status; thresholds, dwell and clear set over the serial control port, control bits by the ctrl_bits_en pin.
 * Assumes one converter sample per ref_clk from same-clock logic, with
 * its overrange flag and virtual converter index alongside.
 */
// Overview of operation
// - Alarm output rises as soon as sample magnitude exceeds upper threshold.
// - Alarm falls only after magnitude stays below lower threshold beyond dwell.
// - Upper threshold lives in registers 0x0247 and 0x0248, compared to magnitude.
// - Alarm rises within 28 clocks of the crossing sample.
// - Lower threshold is 13 bits over 0x0249 and 0x024A, compared to magnitude.
// - Threshold code over two to the thirteenth gives fraction of full scale.
// - Dwell time of 1 to 65535 cycles held at 0x024B and 0x024C.
// - Lower comparison uses full converter resolution after pipeline delay.
// - Overrange indicator follows with the same latency as its sample.
// - With control bits enabled, overrange rides in a sample control bit.
// - Overrange per virtual converter sets a sticky bit in 0x0563.
`timescale 1ns/10ps

module ofd_top
    import ofd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic spi_sclk,
    input wire logic spi_csb,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic [`OFD_SAMPLE_W-1:0] sample_in,
    input wire logic sample_ovr,
    input wire logic [`OFD_VC_W-1:0] sample_vc,
    input wire logic ctrl_bits_en,
    output logic [`OFD_SAMPLE_W-1:0] sample_out,
    output logic sample_ctrl_bit,
    output logic threshold_alarm_output
);

    logic [1:0] rst_pipe_r;
    logic rst_sync_b;
    ofd_bus_s bus;
    logic [7:0] rd_data;
    ofd_core_s st_r;
    ofd_core_s st_nxt;

    // Reset enters asynchronously but is released through two flops
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe_r[1];

    ofd_spi u_spi (
        .ref_clk(ref_clk),
        .rst_sync_b(rst_sync_b),
        .spi_sclk(spi_sclk),
        .spi_csb(spi_csb),
        .spi_sdi(spi_sdi),
        .rd_data(rd_data),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe),
        .bus(bus)
    );

    // Two's complement magnitude; the most negative code maps exactly to 8192
    function automatic logic [`OFD_SAMPLE_W-1:0] abs_mag(
        input logic [`OFD_SAMPLE_W-1:0] s
    );
        if (s[`OFD_SAMPLE_W-1]) begin
            abs_mag = ~s + 14'h0001;
        end else begin
            abs_mag = s;
        end
    endfunction

    function automatic logic [7:0] hi_part(input logic [15:0] v);
        hi_part = v[15:8];
    endfunction

    // Register read mux; unmapped addresses read zero
    always_comb begin
        rd_data = 8'h00;
        unique case (bus.addr)
            `OFD_ADDR_UPPER_P0: rd_data = st_r.upper[7:0];
            `OFD_ADDR_UPPER_P1: rd_data = hi_part({3'h0, st_r.upper});
            `OFD_ADDR_LOWER_P0: rd_data = st_r.lower[7:0];
            `OFD_ADDR_LOWER_P1: rd_data = hi_part({3'h0, st_r.lower});
            `OFD_ADDR_DWELL_P0: rd_data = st_r.dwell[7:0];
            `OFD_ADDR_DWELL_P1: rd_data = hi_part(st_r.dwell);
            `OFD_ADDR_OVR_CLR: rd_data = st_r.clr;
            `OFD_ADDR_OVR_STAT: rd_data = st_r.sticky & ~st_r.clr;
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        logic [`OFD_DWELL_W:0] dwell_eff;
        logic [`OFD_DWELL_W:0] cnt_inc;
        logic [`OFD_VC_N-1:0] ovr_hit;
        dwell_eff = {1'b0, st_r.dwell};
        cnt_inc = st_r.dwell_cnt + 17'h00001;
        ovr_hit = '0;
        st_nxt = st_r;

        if (bus.wr) begin
            unique case (bus.addr)
                `OFD_ADDR_UPPER_P0: st_nxt.upper[7:0] = bus.wdata;
                `OFD_ADDR_UPPER_P1: st_nxt.upper[12:8] = bus.wdata[4:0];
                `OFD_ADDR_LOWER_P0: st_nxt.lower[7:0] = bus.wdata;
                `OFD_ADDR_LOWER_P1: st_nxt.lower[12:8] = bus.wdata[4:0];
                `OFD_ADDR_DWELL_P0: st_nxt.dwell[7:0] = bus.wdata;
                `OFD_ADDR_DWELL_P1: st_nxt.dwell[15:8] = bus.wdata;
                `OFD_ADDR_OVR_CLR: st_nxt.clr = bus.wdata;
                default: st_nxt.clr = st_r.clr;
            endcase
        end

        // A dwell of zero is outside the legal range and acts as one
        if (st_r.dwell == 16'h0000) begin
            dwell_eff = 17'h00001;
        end

        // Stage 1: magnitude at full resolution, sample and its flag together
        st_nxt.mag = abs_mag(sample_in);
        st_nxt.data = sample_in;
        st_nxt.ctrl_bit = ctrl_bits_en && sample_ovr;

        // Held clear bit forces the sticky bit low until it is released
        ovr_hit[sample_vc] = sample_ovr;
        st_nxt.sticky = (st_r.sticky | ovr_hit) & ~st_r.clr;

        // Stage 2: 13-bit codes sit on the same scale as the magnitude
        if (st_r.mag > {1'b0, st_r.upper}) begin
            st_nxt.alarm = 1'b1;
            st_nxt.dwell_cnt = '0;
        end else if (st_r.alarm) begin
            if (st_r.mag < {1'b0, st_r.lower}) begin
                if (cnt_inc > dwell_eff) begin
                    st_nxt.alarm = 1'b0;
                    st_nxt.dwell_cnt = '0;
                end else begin
                    st_nxt.dwell_cnt = cnt_inc;
                end
            end else begin
                st_nxt.dwell_cnt = '0;
            end
        end else begin
            st_nxt.dwell_cnt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r <= '0;
            st_r.upper <= `OFD_UPPER_RST;
            st_r.lower <= `OFD_LOWER_RST;
            st_r.dwell <= `OFD_DWELL_RST;
            st_r.clr <= `OFD_CLR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sample_out = st_r.data;
    assign sample_ctrl_bit = st_r.ctrl_bit;
    assign threshold_alarm_output = st_r.alarm;

endmodule

// File: verif/ofd_assertions.sv
/* Port checker for ofd_top.
   Assumes a bind from the testbench; inputs mirror the top ports. */
`timescale 1ns/10ps
module ofd_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic spi_csb,
    input wire logic spi_sdo_oe,
    input wire logic [13:0] sample_in,
    input wire logic sample_ovr,
    input wire logic ctrl_bits_en,
    input wire logic [13:0] sample_out,
    input wire logic sample_ctrl_bit,
    input wire logic threshold_alarm_output
);
    // Waits three flops, one past the design's two-flop release, so early edges are not judged
    logic [2:0] rdy_r;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) rdy_r <= 3'h0;
        else rdy_r <= {rdy_r[1:0], 1'b1};
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b || !rdy_r[2]);
    out_delay_a: assert property (sample_out == $past(sample_in))
        else $error("sample_out not one cycle behind sample_in");
    ctrl_bit_a: assert property (sample_ctrl_bit == $past(sample_ovr && ctrl_bits_en))
        else $error("control bit does not follow overrange");
    ctrl_off_a: assert property (!$past(ctrl_bits_en) |-> !sample_ctrl_bit)
        else $error("control bit set while control bits off");
    alarm_rise_a: assert property (sample_in == 14'h2000 |-> ##2 threshold_alarm_output)
        else $error("alarm late after full scale sample");
    alarm_hold_a: assert property (sample_in == 14'h2000 |-> ##3 threshold_alarm_output)
        else $error("alarm dropped before dwell");
    alarm_fall_a: assert property ($fell(threshold_alarm_output) |->
        $past(sample_in, 2) != 14'h2000 && $past(sample_in, 3) != 14'h2000)
        else $error("alarm fell too soon after full scale");
    oe_rise_a: assert property ($rose(spi_sdo_oe) |-> !spi_csb)
        else $error("sdo enabled outside a frame");
    oe_idle_a: assert property (spi_csb [*5] |-> !spi_sdo_oe)
        else $error("sdo enabled while deselected");
    cover property ($rose(threshold_alarm_output));
    cover property ($fell(threshold_alarm_output));
    cover property ($rose(spi_sdo_oe));
endmodule

// File: verif/ofd_agc_model.sv
/* Gain control partner: counts alarm rises, cuts gain while alarm high.
   Assumes the alarm is synchronous to ref_clk. */
`timescale 1ns/10ps
module ofd_agc_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic alarm,
    output logic [7:0] rise_cnt,
    output logic gain_cut
);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gain_cut <= 1'b0;
            rise_cnt <= 8'h00;
        end else begin
            gain_cut <= alarm;
            if (alarm && !gain_cut) rise_cnt <= rise_cnt + 8'h01;
        end
    end
endmodule

// File: verif/testbench.sv
/* Self-checking bench for ofd_top: serial port tasks, sample feeds.
   Assumes the design and checker files are compiled first. */
`timescale 1ns/10ps
module testbench;
    logic ref_clk = 0, rst_b = 0, spi_sclk = 0, spi_csb = 1, spi_sdi = 0;
    logic sample_ovr = 0, ctrl_bits_en = 0;
    logic [13:0] sample_in = 14'h0000;
    logic [2:0] sample_vc = 3'h0;
    logic spi_sdo, spi_sdo_oe, sample_ctrl_bit, threshold_alarm_output;
    logic [13:0] sample_out;
    logic [7:0] rises, rd;
    logic hist[$];
    logic [13:0] seq[$];
    int errors = 0, cmp_count = 0, cyc = 0;
    logic [14:0] ra[8] = '{15'h247, 15'h248, 15'h249, 15'h24A, 15'h24B, 15'h24C,
        15'h562, 15'h563};
    logic [7:0] rv[8] = '{8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] wv[6] = '{8'hFF, 8'hEF, 8'h1D, 8'hEA, 8'h03, 8'h5A};
    logic [7:0] ev[6] = '{8'hFF, 8'h0F, 8'h1D, 8'h0A, 8'h03, 8'h5A};
    ofd_top dut (.ref_clk, .rst_b, .spi_sclk, .spi_csb, .spi_sdi, .spi_sdo, .spi_sdo_oe,
        .sample_in, .sample_ovr, .sample_vc, .ctrl_bits_en, .sample_out,
        .sample_ctrl_bit, .threshold_alarm_output);
    ofd_agc_model agc (.ref_clk, .rst_b, .alarm(threshold_alarm_output),
        .rise_cnt(rises), .gain_cut());
    initial forever #20 ref_clk = ~ref_clk;
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // The sclk high phase lasts 5 clocks and the low phase 10, above the synchroniser's minimum
    task spi(input logic r, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] f;
        f = {r, a, d};
        spi_csb <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            tick(5);
            spi_sdi <= f[i];
            tick(5);
            spi_sclk <= 1'b1;
            if (i < 8) rd[i] = spi_sdo;
            tick(5);
            spi_sclk <= 1'b0;
        end
        tick(5);
        spi_csb <= 1'b1;
        tick(5);
    endtask
    task rdc(input logic [14:0] a, input logic [7:0] exp);
        spi(1'b1, a, 8'h00);
        chk("register", {8'h00, rd}, {8'h00, exp});
    endtask
    task play();
        hist = {};
        foreach (seq[i]) begin
            @(posedge ref_clk);
            sample_in <= seq[i];
            #1;
            hist.push_back(threshold_alarm_output);
        end
    endtask
    task ovr_hit(input logic [2:0] v, input logic e);
        @(posedge ref_clk);
        sample_ovr <= 1'b1;
        sample_vc <= v;
        ctrl_bits_en <= e;
        @(posedge ref_clk);
        sample_ovr <= 1'b0;
        #1;
    endtask
    task end_of_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        tick(8);
        rst_b <= 1'b1;
        tick(6);
        for (int i = 0; i < 8; i++) rdc(ra[i], rv[i]);
        rdc(15'h100, 8'h00);
        for (int i = 0; i < 6; i++) begin
            spi(1'b0, ra[i], wv[i]);
            rdc(ra[i], ev[i]);
        end
        // Upper dwell byte back to zero so the first three alarm tests run with a dwell of 3
        spi(1'b0, ra[5], 8'h00);
        $display("register test done");
        seq = '{14'h1000, 0, 0, 14'h0A1D, 0, 0, 0, 0, 0, 0, 0};
        play();
        chk("alarm", {hist[1], hist[2], hist[8], hist[9]}, 4'h6);
        seq = '{14'h3000, 0, 0, 0, 0, 0, 0, 0};
        play();
        chk("alarm", {hist[2], hist[5], hist[6]}, 3'h6);
        seq = '{14'h0FFF, 14'h3001, 14'h2000, 0, 0, 0, 0, 0, 0, 0};
        play();
        chk("alarm", {hist[2], hist[3], hist[4], hist[8]}, 4'b0010);
        chk("agc rises", {8'h00, rises}, 16'h0003);
        // A dwell of zero must behave as one: two quiet samples drop the alarm
        spi(1'b0, 15'h24B, 8'h00);
        seq = '{14'h1000, 0, 0, 0, 0, 0};
        play();
        chk("alarm", {hist[3], hist[4]}, 2'h2);
        $display("alarm test done");
        ovr_hit(3'h5, 1'b1);
        chk("control bit", {15'h0, sample_ctrl_bit}, 16'h0001);
        ovr_hit(3'h0, 1'b0);
        chk("control bit", {15'h0, sample_ctrl_bit}, 16'h0000);
        rdc(15'h563, 8'h21);
        spi(1'b0, 15'h562, 8'h20);
        rdc(15'h563, 8'h01);
        ovr_hit(3'h5, 1'b1);
        rdc(15'h563, 8'h01);
        spi(1'b0, 15'h562, 8'h00);
        rdc(15'h563, 8'h01);
        ovr_hit(3'h5, 1'b0);
        rdc(15'h563, 8'h21);
        $display("overrange test done");
        end_of_test();
    end
endmodule
bind ofd_top ofd_checker chk_i (.ref_clk, .rst_b, .spi_csb, .spi_sdo_oe, .sample_in,
    .sample_ovr, .ctrl_bits_en, .sample_out, .sample_ctrl_bit, .threshold_alarm_output);
